/* cedt_pkg.sv */
// constants, register map and carrier types for the error diagnostic block
package cedt_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  // register indices on the plain register port
  localparam logic [3:0] OFS_GLOBAL_CONFIG = 4'h0;
  localparam logic [3:0] OFS_ERR_COUNTERS  = 4'h1;
  localparam logic [3:0] OFS_ERR_DIAG      = 4'h2;
  localparam logic [3:0] OFS_BIT_TIMER     = 4'h3;
  localparam logic [3:0] OFS_IRQ_ENABLE    = 4'h4;
  localparam logic [3:0] OFS_IRQ_PENDING   = 4'h5;
  localparam logic [3:0] OFS_IRQ_CLEAR     = 4'h6;

  // global_config_reg fields
  localparam int unsigned CFG_ENABLE_BIT = 0;
  localparam int unsigned CFG_TIMESTAMP_ENABLE_BIT = 1;
  localparam int unsigned CFG_TXPOL_BIT  = 2;
  localparam int unsigned CFG_RXPOL_BIT  = 3;
  localparam logic [3:0]  CFG_RESET      = 4'h0;

  // error interrupt enable, pending and clear share bit 15
  localparam int unsigned ERR_IRQ_BIT = 15;

  // error_diag_reg fields
  localparam int unsigned DIAG_FIELD_LSB = 0;
  localparam int unsigned DIAG_POS_LSB   = 4;
  localparam int unsigned DIAG_TXE_BIT   = 10;
  localparam int unsigned DIAG_STUFF_BIT = 11;
  localparam int unsigned DIAG_CRC_BIT   = 12;
  localparam int unsigned DIAG_MON_BIT   = 13;
  localparam int unsigned DIAG_DRIVE_BIT = 14;
  localparam int unsigned DIAG_RSVD_BIT  = 15;

  localparam logic [15:0] REG16_RESET = 16'h0000;
  localparam logic [7:0]  CNT8_RESET  = 8'h00;
  localparam logic [5:0]  POS_RESET   = 6'h00;

  // frame field codes
  localparam logic [3:0] FLD_ERROR        = 4'h0;
  localparam logic [3:0] FLD_ERROR_DEL    = 4'h1;
  localparam logic [3:0] FLD_ERROR_ECHO   = 4'h2;
  localparam logic [3:0] FLD_BUS_IDLE     = 4'h3;
  localparam logic [3:0] FLD_ACK          = 4'h4;
  localparam logic [3:0] FLD_EOF          = 4'h5;
  localparam logic [3:0] FLD_INTERMISSION = 4'h6;
  localparam logic [3:0] FLD_SUSPEND_TX   = 4'h7;
  localparam logic [3:0] FLD_SOF          = 4'h8;
  localparam logic [3:0] FLD_ARBITRATION  = 4'h9;
  localparam logic [3:0] FLD_IDE          = 4'ha;
  localparam logic [3:0] FLD_EXT_ARB      = 4'hb;
  localparam logic [3:0] FLD_R1_R0        = 4'hc;
  localparam logic [3:0] FLD_DLC          = 4'hd;
  localparam logic [3:0] FLD_DATA         = 4'he;
  localparam logic [3:0] FLD_CRC          = 4'hf;

  // bus levels inside the block, before pin polarity
  localparam logic LVL_RECESSIVE = 1'b1;

  typedef struct packed {
    logic       start;  // new frame field begins this cycle
    logic [3:0] code;   // field code
    logic [5:0] len;    // field length in bits
  } cedt_field_t;

  typedef struct packed {
    logic detect;       // bus error detected this cycle
    logic stuff;        // stuffing rule violated
    logic crc;          // received crc invalid
  } cedt_err_t;

  typedef struct packed {
    logic tx_bit;       // bit the protocol engine wants on the bus
    logic is_tx;        // engine is the active transmitter
    logic ack_slot;     // acknowledge slot as receiver
    logic err_flag;     // sending an active error flag
  } cedt_drive_t;

  typedef struct packed {
    logic       load;   // new counter values
    logic [7:0] rx_error_count;
    logic [7:0] tx_error_count;
  } cedt_cnt_t;

  typedef struct packed {
    logic       valid;  // message buffer transfer completed
    logic [3:0] buf_idx;
  } cedt_done_t;

  typedef struct packed {
    logic        valid;   // write stamp into buffer
    logic [3:0]  buf_idx;
    logic [15:0] stamp;
  } cedt_stamp_t;

endpackage

/* cedt_error_diag.sv */
// error counters, last-error diagnostic, bit timer and bus pin stage
// Contract
// - read-only register: receive count high byte, transmit count low byte
// - read-only diagnostic of the latest bus error, cleared by reset
// - bits 3..0 hold the field code of the errored field
// - bits 9..4 hold bit position, loaded length-1, decremented per bit
// - bit 10 set when the block was transmitter at the error
// - bit 11 set when the error was a stuffing violation
// - bit 12 flags invalid crc, meaningful only in the ack field
// - bit 13 holds the receive pin level at the error
// - bit 14 holds the transmit pin level at the error
// - as receiver, drive bus only in ack slot or active error flag
// - free-running 16-bit bit counter, zero after reset
// - with stamp enable, buffer 0 transfer clears the bit counter
// - each good frame copies the bit counter into the buffer stamp
// - disabling also disables the receive pin
// - configuration is kept across disable and re-enable
// - one transmit and one receive pin, each with its polarity flag
// - any counter change sets error pending, interrupt when enabled
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module cedt_error_diag (
  input  wire logic                   clk,         // 200 MHz system clock
  input  wire logic                   resetn,      // async reset, low
  input  wire logic [3:0]             reg_addr,    // register index
  input  wire logic [15:0]            reg_wdata,   // write data
  input  wire logic                   reg_wr,      // write strobe
  input  wire logic                   reg_rd,      // read strobe
  output logic [15:0]                 reg_rdata,   // read data, next cycle
  input  wire logic                   bit_tick,    // one pulse per can bit
  input  wire cedt_pkg::cedt_field_t  field_in,    // field start marker
  input  wire cedt_pkg::cedt_err_t    err_in,      // error detection
  input  wire cedt_pkg::cedt_drive_t  drive_in,    // engine drive request
  input  wire cedt_pkg::cedt_cnt_t    cnt_in,      // error counter update
  input  wire cedt_pkg::cedt_done_t   done_in,     // buffer transfer done
  output var  cedt_pkg::cedt_stamp_t  stamp_out,   // stamp write to buffer
  output logic                        rx_bit,      // received bus level
  output logic                        ctrl_enable, // controller enabled
  output logic                        err_irq,     // error interrupt
  input  wire logic                   bus_rx_pin,  // receive pin
  output logic                        bus_tx_pin   // transmit pin
);

  ////////////////////////////////////////////////////////////////////////
  // register port decode

  logic [3:0]  cfg_q;
  logic        ien_q;
  logic        ipend_q;
  logic [7:0]  rec_q;
  logic [7:0]  tec_q;
  logic [15:0] diag_q;
  logic [15:0] tmr_q;
  logic [5:0]  pos_q;
  logic [3:0]  field_q;
  logic        rx_s1_q;
  logic        rx_s2_q;
  logic        rx_s3_q;
  logic        rx_pin_q;
  logic [15:0] rd_d;

  logic wr_cfg;
  logic wr_ien;
  logic wr_clr;
  logic tmr_clear;
  logic cnt_changed;
  logic tx_level;

  assign wr_cfg = reg_wr && (reg_addr == cedt_pkg::OFS_GLOBAL_CONFIG);
  assign wr_ien = reg_wr && (reg_addr == cedt_pkg::OFS_IRQ_ENABLE);
  assign wr_clr = reg_wr && (reg_addr == cedt_pkg::OFS_IRQ_CLEAR)
                  && reg_wdata[cedt_pkg::ERR_IRQ_BIT];

  // configuration survives a disable; only reset clears it
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cfg_q <= cedt_pkg::CFG_RESET;
    else if (wr_cfg)
      cfg_q <= reg_wdata[3:0];
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ien_q <= 1'b0;
    else if (wr_ien)
      ien_q <= reg_wdata[cedt_pkg::ERR_IRQ_BIT];
  end

  assign ctrl_enable = cfg_q[cedt_pkg::CFG_ENABLE_BIT];

  // read-only registers simply have no write path
  always_comb
  begin
    rd_d = cedt_pkg::REG16_RESET;
    unique case (reg_addr)
      cedt_pkg::OFS_GLOBAL_CONFIG: rd_d = {12'h000, cfg_q};
      cedt_pkg::OFS_ERR_COUNTERS:  rd_d = {rec_q, tec_q};
      cedt_pkg::OFS_ERR_DIAG:      rd_d = diag_q;
      cedt_pkg::OFS_BIT_TIMER:     rd_d = tmr_q;
      cedt_pkg::OFS_IRQ_ENABLE:    rd_d = {ien_q, 15'h0000};
      cedt_pkg::OFS_IRQ_PENDING:   rd_d = {ipend_q, 15'h0000};
      default:                     rd_d = cedt_pkg::REG16_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= cedt_pkg::REG16_RESET;
    else if (reg_rd)
      reg_rdata <= rd_d;
    else
      reg_rdata <= cedt_pkg::REG16_RESET;
  end

  ////////////////////////////////////////////////////////////////////////
  // error counters and error interrupt

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rec_q <= cedt_pkg::CNT8_RESET;
      tec_q <= cedt_pkg::CNT8_RESET;
    end
    else if (cnt_in.load)
    begin
      rec_q <= cnt_in.rx_error_count;
      tec_q <= cnt_in.tx_error_count;
    end
  end

  assign cnt_changed = cnt_in.load
                       && ({cnt_in.rx_error_count, cnt_in.tx_error_count} != {rec_q, tec_q});

  // a change landing with a clear still leaves the flag set
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ipend_q <= 1'b0;
    else if (cnt_changed)
      ipend_q <= 1'b1;
    else if (wr_clr)
      ipend_q <= 1'b0;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      err_irq <= 1'b0;
    else
      err_irq <= (ipend_q || cnt_changed) && ien_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // field tracking and last-error capture

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      field_q <= cedt_pkg::FLD_ERROR;
      pos_q   <= cedt_pkg::POS_RESET;
    end
    else if (field_in.start)
    begin
      field_q <= field_in.code;
      pos_q   <= field_in.len - 6'h01;
    end
    else if (bit_tick)
      pos_q <= pos_q - 6'h01;
  end

  // only the newest error is kept; older records are overwritten
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      diag_q <= cedt_pkg::REG16_RESET;
    else if (err_in.detect)
    begin
      diag_q[cedt_pkg::DIAG_RSVD_BIT]  <= 1'b0;
      diag_q[cedt_pkg::DIAG_DRIVE_BIT] <= bus_tx_pin;
      diag_q[cedt_pkg::DIAG_MON_BIT]   <= rx_pin_q;
      diag_q[cedt_pkg::DIAG_CRC_BIT]   <= err_in.crc;
      diag_q[cedt_pkg::DIAG_STUFF_BIT] <= err_in.stuff;
      diag_q[cedt_pkg::DIAG_TXE_BIT]   <= drive_in.is_tx;
      diag_q[9:4] <= pos_q;
      diag_q[3:0] <= field_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bit timer and time stamps

  assign tmr_clear = done_in.valid && (done_in.buf_idx == 4'h0)
                     && cfg_q[cedt_pkg::CFG_TIMESTAMP_ENABLE_BIT];

  // a clear in the same cycle as a bit wins: buffer 0 restarts the base
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      tmr_q <= cedt_pkg::REG16_RESET;
    else if (tmr_clear)
      tmr_q <= cedt_pkg::REG16_RESET;
    else if (bit_tick)
      tmr_q <= tmr_q + 16'h0001;
  end

  // the stamp carries the value before any clear of this same cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      stamp_out <= '0;
    else
    begin
      stamp_out.valid   <= done_in.valid;
      stamp_out.buf_idx <= done_in.buf_idx;
      stamp_out.stamp   <= tmr_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus pins

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
    end
    else
    begin
      rx_s1_q <= bus_rx_pin;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
    end
  end

  // a level counts only once two stages past the first agree
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rx_pin_q <= 1'b1;
    else if (rx_s2_q == rx_s3_q)
      rx_pin_q <= rx_s3_q;
  end

  // disabled controller ignores the pin, so keep rx wake-up elsewhere
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rx_bit <= cedt_pkg::LVL_RECESSIVE;
    else if (!ctrl_enable)
      rx_bit <= cedt_pkg::LVL_RECESSIVE;
    else
      rx_bit <= rx_pin_q ^ cfg_q[cedt_pkg::CFG_RXPOL_BIT];
  end

  always_comb
  begin
    if (!ctrl_enable)
      tx_level = cedt_pkg::LVL_RECESSIVE;
    else if (drive_in.is_tx || drive_in.ack_slot || drive_in.err_flag)
      tx_level = drive_in.tx_bit;
    else
      tx_level = cedt_pkg::LVL_RECESSIVE;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      bus_tx_pin <= cedt_pkg::LVL_RECESSIVE;
    else
      bus_tx_pin <= tx_level ^ cfg_q[cedt_pkg::CFG_TXPOL_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  cnt_read_a:
    assert property (@(posedge clk) disable iff (!resetn)
      reg_rd && reg_addr == cedt_pkg::OFS_ERR_COUNTERS
      |=> reg_rdata == {$past(rec_q), $past(tec_q)})
    else $error("error counter read mismatch");

  diag_field_a:
    assert property (@(posedge clk) disable iff (!resetn)
      err_in.detect |=> diag_q[3:0] == $past(field_q))
    else $error("diag field code not captured");

  pos_load_a:
    assert property (@(posedge clk) disable iff (!resetn)
      field_in.start ##1 (bit_tick && !field_in.start)
      |=> pos_q == $past(field_in.len, 2) - 6'h02)
    else $error("bit position load or count wrong");

  diag_txe_a:
    assert property (@(posedge clk) disable iff (!resetn)
      err_in.detect |=> diag_q[10] == $past(drive_in.is_tx)
                        && diag_q[11] == $past(err_in.stuff)
                        && diag_q[12] == $past(err_in.crc))
    else $error("diag error type bits wrong");

  diag_lines_a:
    assert property (@(posedge clk) disable iff (!resetn)
      err_in.detect |=> diag_q[13] == $past(rx_pin_q)
                        && diag_q[14] == $past(bus_tx_pin))
    else $error("diag line samples wrong");

  diag_hold_a:
    assert property (@(posedge clk) disable iff (!resetn)
      !err_in.detect |=> $stable(diag_q) && !diag_q[15])
    else $error("diag changed without an error");

  rx_quiet_a:
    assert property (@(posedge clk) disable iff (!resetn)
      !drive_in.is_tx && !drive_in.ack_slot && !drive_in.err_flag
      |=> bus_tx_pin == ~$past(cfg_q[cedt_pkg::CFG_TXPOL_BIT]))
    else $error("receiver drove the bus");

  tmr_inc_a:
    assert property (@(posedge clk) disable iff (!resetn)
      bit_tick && !tmr_clear |=> tmr_q == $past(tmr_q) + 16'h0001)
    else $error("bit timer did not advance");

  tmr_clr_a:
    assert property (@(posedge clk) disable iff (!resetn)
      tmr_clear |=> tmr_q == 16'h0000)
    else $error("bit timer not cleared by buffer 0");

  stamp_cap_a:
    assert property (@(posedge clk) disable iff (!resetn)
      done_in.valid |=> stamp_out.valid && stamp_out.stamp == $past(tmr_q))
    else $error("time stamp not captured");

  rx_off_a:
    assert property (@(posedge clk) disable iff (!resetn)
      !ctrl_enable |=> rx_bit == cedt_pkg::LVL_RECESSIVE)
    else $error("receive pin seen while disabled");

  irq_set_a:
    assert property (@(posedge clk) disable iff (!resetn)
      cnt_changed |=> ipend_q ##0 (err_irq == $past(ien_q)))
    else $error("counter change did not set pending");

  err_txer_c: cover property (@(posedge clk) disable iff (!resetn)
    err_in.detect && drive_in.is_tx);
  stamp_buf0_c: cover property (@(posedge clk) disable iff (!resetn)
    tmr_clear && bit_tick);
  irq_clear_c: cover property (@(posedge clk) disable iff (!resetn)
    cnt_changed && wr_clr);

endmodule

`default_nettype wire

/* cedt_bus_model.sv */
// transceiver stand-in: wired-and of this node and one other bus node
`timescale 1ns/1ps
`default_nettype none

module cedt_bus_model (
  input  wire logic tx_pin,    // transmit pin of the node under test
  input  wire logic other_dom, // another node drives dominant
  output logic      rx_pin     // level returned to the receive pin
);
  // dominant is low and wins; an idle line floats back to recessive
  assign rx_pin = tx_pin & ~other_dom;
endmodule

`default_nettype wire

/* cedt_error_diag_tb.sv */
// self-checking bench for the error diagnostic and bit timer block
`timescale 1ns/1ps
`default_nettype none

module cedt_error_diag_tb;
  logic                  clk;
  logic                  resetn;
  logic [3:0]            reg_addr;
  logic [15:0]           reg_wdata;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [15:0]           reg_rdata;
  logic                  bit_tick;
  cedt_pkg::cedt_field_t field_in;
  cedt_pkg::cedt_err_t   err_in;
  cedt_pkg::cedt_drive_t drive_in;
  cedt_pkg::cedt_cnt_t   cnt_in;
  cedt_pkg::cedt_done_t  done_in;
  cedt_pkg::cedt_stamp_t stamp_out;
  logic                  rx_bit;
  logic                  ctrl_enable;
  logic                  err_irq;
  logic                  bus_rx_pin;
  logic                  bus_tx_pin;
  logic                  other_dom;
  int                    miscompares;
  int                    n_compared;
  logic [15:0]           rd;

  cedt_error_diag cedt_error_diag_inst (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bit_tick(bit_tick), .field_in(field_in),
    .err_in(err_in), .drive_in(drive_in), .cnt_in(cnt_in),
    .done_in(done_in), .stamp_out(stamp_out), .rx_bit(rx_bit),
    .ctrl_enable(ctrl_enable), .err_irq(err_irq),
    .bus_rx_pin(bus_rx_pin), .bus_tx_pin(bus_tx_pin)
  );

  cedt_bus_model cedt_bus_model_inst (
    .tx_pin(bus_tx_pin), .other_dom(other_dom), .rx_pin(bus_rx_pin)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
    rd_reg(a, rd);
    chk("register", exp, rd);
  endtask

  task automatic load_cnt(input logic [7:0] r, input logic [7:0] t);
    @(posedge clk);
    cnt_in <= {1'b1, r, t};
    @(posedge clk);
    cnt_in.load <= 1'b0;
  endtask

  task automatic fld(input logic [3:0] code, input logic [5:0] len);
    @(posedge clk);
    field_in <= {1'b1, code, len};
    @(posedge clk);
    field_in.start <= 1'b0;
  endtask

  task automatic det(input logic s, input logic c);
    @(posedge clk);
    err_in <= {1'b1, s, c};
    @(posedge clk);
    err_in <= 3'b000;
  endtask

  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge clk);
      bit_tick <= 1'b1;
    end
    @(posedge clk);
    bit_tick <= 1'b0;
  endtask

  task automatic done_pulse(input logic [3:0] idx, input logic [15:0] s);
    @(posedge clk);
    done_in <= {1'b1, idx};
    @(posedge clk);
    done_in.valid <= 1'b0;
    #1;
    chk("stamp", s, stamp_out.stamp);
    chk("stamp buf", {11'h0, 1'b1, idx},
        {11'h0, stamp_out.valid, stamp_out.buf_idx});
  endtask

  task automatic pin_case(input logic [3:0] cfg, input logic [3:0] drv,
                          input logic dom, input logic [1:0] exp);
    wr(cedt_pkg::OFS_GLOBAL_CONFIG, {12'h000, cfg});
    @(posedge clk);
    drive_in  <= drv;
    other_dom <= dom;
    cyc(8);
    #1;
    chk("tx pin, rx bit", {14'h0, exp}, {14'h0, bus_tx_pin, rx_bit});
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk(cedt_pkg::OFS_ERR_COUNTERS, 16'h0000);
    rchk(cedt_pkg::OFS_ERR_DIAG, 16'h0000);
    rchk(cedt_pkg::OFS_BIT_TIMER, 16'h0000);
    rchk(4'hf, 16'h0000);
    chk("idle pins", 16'h0003, {14'h0, bus_tx_pin, rx_bit});
    chk("enable after reset", 16'h0000, {15'h0, ctrl_enable});
  endtask

  task automatic t_counters;
    load_cnt(8'ha5, 8'h3c);
    cyc(2);
    #1;
    chk("irq masked", 16'h0000, {15'h0, err_irq});
    wr(cedt_pkg::OFS_ERR_COUNTERS, 16'hffff);
    rchk(cedt_pkg::OFS_ERR_COUNTERS, 16'ha53c);
    rchk(cedt_pkg::OFS_IRQ_PENDING, 16'h8000);
    wr(cedt_pkg::OFS_IRQ_ENABLE, 16'h8000);
    cyc(2);
    #1;
    chk("irq raised", 16'h0001, {15'h0, err_irq});
    wr(cedt_pkg::OFS_IRQ_CLEAR, 16'h8000);
    load_cnt(8'ha5, 8'h3c);
    cyc(2);
    #1;
    chk("irq no change", 16'h0000, {15'h0, err_irq});
    load_cnt(8'ha5, 8'h3d);
    cyc(2);
    #1;
    chk("irq on change", 16'h0001, {15'h0, err_irq});
    wr(cedt_pkg::OFS_IRQ_CLEAR, 16'h8000);
  endtask

  task automatic t_diag;
    logic [4:0] c;
    // every field code, receiver role, recessive line
    for (c = 5'h00; c < 5'h10; c++)
    begin
      fld(c[3:0], {2'b00, c[3:0]} + 6'h01);
      det(c[0], c[1]);
      rchk(cedt_pkg::OFS_ERR_DIAG,
           {3'b011, c[1], c[0], 3'b000, c[3:0], c[3:0]});
    end
    // transmitter driving dominant, position counted down by two bits
    @(posedge clk);
    drive_in <= 4'b0100;
    cyc(8);
    fld(cedt_pkg::FLD_DATA, 6'h08);
    // first bit lands in the cycle right after the field start
    bit_tick <= 1'b1;
    ticks(1);
    det(1'b1, 1'b0);
    wr(cedt_pkg::OFS_ERR_DIAG, 16'hffff);
    rchk(cedt_pkg::OFS_ERR_DIAG, 16'h0c5e);
    @(posedge clk);
    drive_in <= 4'b1000;
  endtask

  task automatic t_pins;
    pin_case(4'h1, 4'b0000, 1'b0, 2'b11);
    pin_case(4'h1, 4'b0010, 1'b0, 2'b00);
    pin_case(4'h1, 4'b0001, 1'b0, 2'b00);
    pin_case(4'h5, 4'b1100, 1'b0, 2'b00);
    pin_case(4'h9, 4'b1000, 1'b0, 2'b10);
    pin_case(4'h1, 4'b1000, 1'b1, 2'b10);
    // nothing left to send before the controller is switched off
    pin_case(4'h0, 4'b1000, 1'b1, 2'b11);
    chk("enable off", 16'h0000, {15'h0, ctrl_enable});
    pin_case(4'h1, 4'b1000, 1'b0, 2'b11);
    chk("enable on", 16'h0001, {15'h0, ctrl_enable});
    rchk(cedt_pkg::OFS_ERR_COUNTERS, 16'ha53d);
    rchk(cedt_pkg::OFS_GLOBAL_CONFIG, 16'h0001);
  endtask

  task automatic t_timer;
    rchk(cedt_pkg::OFS_BIT_TIMER, 16'h0002);
    ticks(5);
    done_pulse(4'h0, 16'h0007);
    rchk(cedt_pkg::OFS_BIT_TIMER, 16'h0007);
    wr(cedt_pkg::OFS_GLOBAL_CONFIG, 16'h0003);
    done_pulse(4'h3, 16'h0007);
    rchk(cedt_pkg::OFS_BIT_TIMER, 16'h0007);
    done_pulse(4'h0, 16'h0007);
    rchk(cedt_pkg::OFS_BIT_TIMER, 16'h0000);
    ticks(3);
    wr(cedt_pkg::OFS_BIT_TIMER, 16'hffff);
    rchk(cedt_pkg::OFS_BIT_TIMER, 16'h0003);
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    miscompares = 0;
    n_compared  = 0;
    resetn      = 1'b0;
    reg_addr    = 4'h0;
    reg_wdata   = 16'h0000;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    bit_tick    = 1'b0;
    field_in    = '0;
    err_in      = '0;
    drive_in    = 4'b1000;
    cnt_in      = '0;
    done_in     = '0;
    other_dom   = 1'b0;
    cyc(4);
    resetn <= 1'b1;
    t_reset;
    // controller enable first, other registers written by the tests later
    wr(cedt_pkg::OFS_GLOBAL_CONFIG, 16'h0001);
    t_counters;
    t_diag;
    t_pins;
    t_timer;
    test_done;
  end

  // the sequence needs under 300 cycles; this allows over 60 times that
  initial
  begin
    #100000;
    miscompares++;
    test_done;
  end
endmodule

`default_nettype wire
